// *** hw/gp_capture_timer.sv ***
// general purpose 32-bit capture timer with prescaler and time formats
// assumes a single 20 MHz clock, a strobe register port and
// interrupt lines that already run on i_clock
//
// Functional notes
// - format field picks binary or time layout
// - capture latches counter on selected event
// - capture fires on first assertion only
// - timeout pulse can start adc conversions
// - load register, read/write, resets to zero
// - value register read-only, resets all ones
// - config bit 17 enables event capture
// - event select value maps to line plus two
// - clock select: core, 32k, pll, pin
// - config bit 8 counts up, else down
// - config bit 7 enables counter, reset cleared
// - config bit 6 periodic, else free-running
// - prescale divides source by two to field
// - any write to clear register drops timeout flag, not capture
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "gp_timer_params.svh"

module gp_capture_timer (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_srst,
    // register port
    input  wire logic [31:0] i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // count sources from pins, asynchronous to i_clock
    input  wire logic        i_xtal_32k,
    input  wire logic        i_undivided_pll_clock,
    input  wire logic        i_external_count_pin,
    // system interrupt lines, synchronous to i_clock
    input  wire logic [27:0] i_irq_lines,
    // interrupt and conversion start
    output logic             o_irq,
    output logic             o_adc_start
);

    // one step of the time layout; bit 32 flags a full wrap
    // each byte is one digit group; a carry or borrow ripples upwards
    // only while the lower group wrapped, so one call covers a full step
    function automatic logic [32:0] time_step(input logic [31:0] v,
                                             input logic        up,
                                             input logic [7:0]  hmax);
        logic [31:0] r;
        logic [7:0]  lm;
        logic [7:0]  f;
        logic        c;
        r = v;
        c = 1'b1;
        for (int k = 0; k < 4; k++) begin
            lm = (k == 0) ? `GPT_HUND_MAX : ((k == 3) ? hmax : `GPT_MINSEC_MAX);
            f = v[8*k +: 8];
            if (c) begin
                if (up) begin
                    c = (f >= lm);
                    f = c ? 8'h00 : f + 8'h01;
                end else begin
                    c = (f == 8'h00);
                    f = c ? lm : f - 8'h01;
                end
            end
            r[8*k +: 8] = f;
        end
        return {c, r};
    endfunction : time_step

    logic [31:0]            load_ff;
    logic [31:0]            value_ff;
    logic [31:0]            cap_ff;
    logic [`GPT_CFG_W-1:0]  cfg_ff;
    logic [1:0]             stat_ff;
    logic [1:0]             mask_ff;
    logic [14:0]            pre_ff;
    logic                   line_prev_ff;
    logic                   adc_ff;
    logic [31:0]            rdata_ff;
    logic [2:0]             s1_ff;
    logic [2:0]             s2_ff;
    logic [2:0]             s3_ff;
    logic [2:0]             flt_ff;
    logic [2:0]             rise;

    // address decode
    wire wr_load = i_wr && (i_addr == `GPT_ADDR_LOAD);
    wire wr_cfg  = i_wr && (i_addr == `GPT_ADDR_CONFIG);
    wire wr_clr  = i_wr && (i_addr == `GPT_ADDR_IRQ_CLEAR);
    wire wr_mask = i_wr && (i_addr == `GPT_ADDR_MASK);
    wire rd_stat = i_rd && (i_addr == `GPT_ADDR_STATUS);

    // config fields
    wire        cap_en   = cfg_ff[`GPT_CFG_CAPEN];
    wire [4:0]  ev_sel   = cfg_ff[`GPT_CFG_EVSEL_MSB:`GPT_CFG_EVSEL_LSB];
    wire [2:0]  clk_sel  = cfg_ff[`GPT_CFG_CLK_MSB:`GPT_CFG_CLK_LSB];
    wire        cnt_up   = cfg_ff[`GPT_CFG_UP];
    wire        cnt_en   = cfg_ff[`GPT_CFG_EN];
    wire        periodic = cfg_ff[`GPT_CFG_PERIODIC];
    wire [1:0]  fmt      = cfg_ff[`GPT_CFG_FMT_MSB:`GPT_CFG_FMT_LSB];
    wire [3:0]  presc    = cfg_ff[`GPT_CFG_PRE_MSB:`GPT_CFG_PRE_LSB];

    // pin sources: three stages, a rise counts once stages two and three agree
    // a pin with a period under four i_clock cycles will lose edges
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge i_clock) begin
                if (i_srst) begin
                    s2_ff[gi]  <= 1'b0;
                    s3_ff[gi]  <= 1'b0;
                    flt_ff[gi] <= 1'b0;
                end else begin
                    s2_ff[gi]  <= s1_ff[gi];
                    s3_ff[gi]  <= s2_ff[gi];
                    flt_ff[gi] <= (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : flt_ff[gi];
                end
            end
            assign rise[gi] = s2_ff[gi] && s3_ff[gi] && !flt_ff[gi];
        end
    endgenerate

    // first stage has no reset so it only feeds stage two
    always_ff @(posedge i_clock) begin
        s1_ff <= {i_external_count_pin, i_undivided_pll_clock, i_xtal_32k};
    end

    // source select; reserved codes give no ticks
    wire src_tick = (clk_sel == gp_timer_pkg::CS_CORE) ? 1'b1 :
                    (clk_sel == gp_timer_pkg::CS_32K)  ? rise[0] :
                    (clk_sel == gp_timer_pkg::CS_PLL)  ? rise[1] :
                    (clk_sel == gp_timer_pkg::CS_PIN)  ? rise[2] : 1'b0;

    // prescaler: divide by two to the power of the field
    // counts source ticks only, so a slow pin source is divided as well
    wire [14:0] pmask    = 15'((16'h0001 << presc) - 16'h0001);
    wire        pre_hit  = (pre_ff & pmask) == pmask;
    wire        cnt_tick = cnt_en && src_tick && pre_hit;
    wire [14:0] nxt_pre  = !cnt_en ? 15'h0000 :
                           (src_tick ? (pre_hit ? 15'h0000 : pre_ff + 15'h0001) : pre_ff);

    // next count in either layout; reserved format counts as binary
    wire        time_fmt = (fmt == gp_timer_pkg::FMT_HR23) ||
                           (fmt == gp_timer_pkg::FMT_HR255);
    wire [7:0]  hour_max = (fmt == gp_timer_pkg::FMT_HR23) ?
                           `GPT_HOUR23_MAX : `GPT_HOUR255_MAX;
    wire [32:0] bin_up   = {1'b0, value_ff} + 33'h000000001;
    wire [32:0] bin_step = cnt_up ? bin_up :
                           {value_ff == 32'h00000000, value_ff - 32'h00000001};
    wire [32:0] tim_step = time_step(value_ff, cnt_up, hour_max);
    wire [32:0] step     = time_fmt ? tim_step : bin_step;
    wire        terminal = step[32];
    wire        timeout  = cnt_tick && terminal && !wr_load;
    wire [31:0] nxt_value = wr_load ? i_wdata :
                            (!cnt_tick ? value_ff :
                             ((terminal && periodic) ? load_ff : step[31:0]));

    // capture source, first assertion only
    // the previous level is tracked even while capture is off, so a line
    // already high at enable does not fire until it falls and rises again
    wire [5:0] ev_idx   = {1'b0, ev_sel} + `GPT_EVSEL_OFFSET;
    wire       sel_line = (ev_sel <= `GPT_EVSEL_MAX) ? i_irq_lines[ev_idx[4:0]] : 1'b0;
    wire       cap_fire = cap_en && sel_line && !line_prev_ff;

    // status: hardware set wins over read clear and clear-register write
    // the clear register touches only the timeout flag, capture stays
    wire [1:0] ev_set   = {cap_fire, timeout};
    wire [1:0] clr_bits = rd_stat ? 2'h3 : (wr_clr ? 2'h1 : 2'h0);
    wire [1:0] nxt_stat = (stat_ff & ~clr_bits) | ev_set;

    // read mux; unmapped and write-only addresses read zero
    // read data are registered and forced to zero outside an answer
    wire [31:0] rmux =
        (i_addr == `GPT_ADDR_LOAD)    ? load_ff :
        (i_addr == `GPT_ADDR_VALUE)   ? value_ff :
        (i_addr == `GPT_ADDR_CONFIG)  ? {14'h0000, cfg_ff} :
        (i_addr == `GPT_ADDR_CAPTURE) ? cap_ff :
        (i_addr == `GPT_ADDR_STATUS)  ? {30'h00000000, stat_ff} :
        (i_addr == `GPT_ADDR_MASK)    ? {30'h00000000, mask_ff} : 32'h00000000;

    // software registers
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            load_ff <= `GPT_LOAD_RST;
            cfg_ff  <= `GPT_CONFIG_RST;
            mask_ff <= `GPT_MASK_RST;
        end else begin
            load_ff <= wr_load ? i_wdata : load_ff;
            cfg_ff  <= wr_cfg ? i_wdata[`GPT_CFG_W-1:0] : cfg_ff;
            mask_ff <= wr_mask ? i_wdata[1:0] : mask_ff;
        end
    end

    // counter and prescaler
    // a load write takes effect at once, ahead of any tick in that cycle
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            value_ff <= `GPT_VALUE_RST;
            pre_ff   <= 15'h0000;
        end else begin
            value_ff <= nxt_value;
            pre_ff   <= nxt_pre;
        end
    end

    // capture, status and outputs
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            cap_ff       <= `GPT_CAPTURE_RST;
            line_prev_ff <= 1'b0;
            stat_ff      <= 2'h0;
            adc_ff       <= 1'b0;
            rdata_ff     <= 32'h00000000;
        end else begin
            cap_ff       <= cap_fire ? value_ff : cap_ff;
            line_prev_ff <= sel_line;
            stat_ff      <= nxt_stat;
            adc_ff       <= timeout;
            rdata_ff     <= i_rd ? rmux : 32'h00000000;
        end
    end

    assign o_rdata     = rdata_ff;
    assign o_adc_start = adc_ff;
    assign o_irq       = |(stat_ff & mask_ff);

    // checks on the design's own behaviour
    // all checks run on i_clock and sleep through reset
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);

    sequence load_write_s;
        wr_load ##1 !wr_load;
    endsequence
    sequence clear_write_s;
        wr_clr && !timeout && !rd_stat;
    endsequence

    load_reset_a: assert property ($past(i_srst) |-> load_ff == 32'h00000000)
        else $error("load register not zero after reset");
    value_reset_a: assert property ($past(i_srst) |-> value_ff == 32'hFFFFFFFF)
        else $error("value register not all ones after reset");
    capture_latch_a: assert property (cap_fire |=> cap_ff == $past(value_ff))
        else $error("capture did not latch the counter");
    capture_once_a: assert property (sel_line && $past(sel_line) && !cap_fire
                                     |=> $stable(cap_ff))
        else $error("capture moved while event line held");
    capture_off_a: assert property (!cap_en |-> !cap_fire)
        else $error("capture fired while disabled");
    adc_pulse_a: assert property (timeout |=> o_adc_start ##1 (o_adc_start == $past(timeout)))
        else $error("conversion start missing after timeout");
    irq_clear_a: assert property (clear_write_s |=> !stat_ff[0])
        else $error("timer interrupt not cleared by write");
    stopped_hold_a: assert property (!cnt_en && !wr_load |=> $stable(value_ff))
        else $error("counter moved while disabled");
    load_apply_a: assert property (load_write_s |-> ##0 1'b1 ##0
                                   value_ff == $past(i_wdata))
        else $error("load write not seen in counter");
    reload_a: assert property (timeout && periodic |=>
                               value_ff == $past(load_ff) && stat_ff[0])
        else $error("periodic reload or interrupt missing");
    count_up_a: assert property (cnt_tick && !time_fmt && cnt_up && !terminal && !wr_load
                                 |=> value_ff == $past(value_ff) + 32'h00000001)
        else $error("binary up count wrong");
    hund_roll_a: assert property (cnt_tick && time_fmt && cnt_up && !wr_load &&
                                  value_ff[7:0] == 8'h63 |=> value_ff[7:0] == 8'h00)
        else $error("hundredths did not roll over");
    hour23_a: assert property (cnt_tick && fmt == 2'h2 && !cnt_up && !wr_load &&
                               value_ff == 32'h00000000 && !periodic
                               |=> value_ff[31:24] == 8'h17)
        else $error("hour wrap not at 23");

    // register port answers: one cycle after the strobe, zero in between
    rdata_idle_a: assert property (!$past(i_rd)
        |-> o_rdata == 32'h00000000)
        else $error("read data not idle zero");
    rdata_read_a: assert property (i_rd
        |=> o_rdata == $past(rmux))
        else $error("read answer not the addressed register");
    cfg_write_a: assert property (wr_cfg
        |=> cfg_ff == $past(i_wdata[`GPT_CFG_W-1:0]))
        else $error("config write not stored");
    mask_write_a: assert property (wr_mask
        |=> mask_ff == $past(i_wdata[1:0]))
        else $error("mask write not stored");
    load_hold_a: assert property (!wr_load
        |=> $stable(load_ff))
        else $error("load register moved without a write");
    value_ro_a: assert property (i_wr && i_addr == `GPT_ADDR_VALUE && !cnt_tick
        |=> $stable(value_ff))
        else $error("value register took a write");

    // one counter step, split by layout and direction
    sequence bin_down_s;
        cnt_tick && !wr_load && !time_fmt && !cnt_up;
    endsequence
    sequence bin_up_s;
        cnt_tick && !wr_load && !time_fmt && cnt_up;
    endsequence
    sequence time_up_s;
        cnt_tick && !wr_load && time_fmt && cnt_up;
    endsequence
    sequence time_down_s;
        cnt_tick && !wr_load && time_fmt && !cnt_up;
    endsequence

    // binary steps and free-running wraps
    count_down_a: assert property (bin_down_s ##0 !terminal
        |=> value_ff == $past(value_ff) - 32'h00000001)
        else $error("binary down count wrong");
    down_wrap_a: assert property (bin_down_s ##0 terminal && !periodic
        |=> value_ff == 32'hFFFFFFFF)
        else $error("down count did not wrap");
    up_wrap_a: assert property (bin_up_s ##0 terminal && !periodic
        |=> value_ff == 32'h00000000)
        else $error("up count did not wrap");

    // time layout carries between digit groups
    sec_roll_a: assert property (time_up_s ##0 value_ff[15:0] == 16'h3B63 && !terminal
        |=> value_ff[15:0] == 16'h0000)
        else $error("seconds did not roll over");
    min_roll_a: assert property (time_down_s ##0 value_ff[23:0] == 24'h000000 && !terminal
        |=> value_ff[23:0] == 24'h3B3B63)
        else $error("minutes did not borrow");
    hour_up_a: assert property (time_up_s ##0 fmt == 2'h2 && !periodic &&
        value_ff == 32'h173B3B63 |=> value_ff == 32'h00000000)
        else $error("hour 23 did not wrap up");
    hour255_a: assert property (time_down_s ##0 fmt == 2'h3 && !periodic &&
        value_ff == 32'h00000000 |=> value_ff[31:24] == 8'hFF)
        else $error("hour wrap not at 255");

    // status flags: set, read clear, clear register
    status_set_a: assert property (timeout
        |=> stat_ff[0])
        else $error("timeout flag not set");
    capture_flag_a: assert property (cap_fire
        |=> stat_ff[1])
        else $error("capture flag not set");
    status_read_a: assert property (rd_stat && !timeout && !cap_fire
        |=> stat_ff == 2'h0)
        else $error("status read did not clear");
    clear_keep_a: assert property (wr_clr && !rd_stat && !cap_fire
        |=> stat_ff[1] == $past(stat_ff[1]))
        else $error("clear register touched capture flag");

    // capture, sources, prescaler, conversion start and timeout while stopped
    capture_hold_a: assert property (!cap_fire
        |=> $stable(cap_ff))
        else $error("capture moved without an event");
    evsel_range_a: assert property (ev_sel > `GPT_EVSEL_MAX
        |-> !sel_line)
        else $error("event select out of range still picks a line");
    src_none_a: assert property (clk_sel > 3'h3
        |-> !cnt_tick)
        else $error("reserved clock select counted");
    sync_single_a: assert property (rise[0]
        |=> !rise[0])
        else $error("one pin rise gave two ticks");
    pre_clear_a: assert property (!cnt_en
        |=> pre_ff == 15'h0000)
        else $error("prescaler kept state while disabled");
    pre_hold_a: assert property (cnt_en && !src_tick
        |=> $stable(pre_ff))
        else $error("prescaler moved without a source tick");
    adc_source_a: assert property (o_adc_start
        |-> $past(timeout))
        else $error("conversion start without a timeout");
    stopped_quiet_a: assert property (!cnt_en
        |-> !timeout)
        else $error("timeout while disabled");

endmodule : gp_capture_timer

// *** inc/gp_timer_params.svh ***
// register map, field positions, reset values and limits of the capture timer
// assumes byte addresses on a 32-bit register port
`ifndef GP_TIMER_PARAMS_SVH
`define GP_TIMER_PARAMS_SVH

// register byte addresses
`define GPT_ADDR_LOAD      32'hFFFF0320
`define GPT_ADDR_VALUE     32'hFFFF0324
`define GPT_ADDR_CONFIG    32'hFFFF0328
`define GPT_ADDR_IRQ_CLEAR 32'hFFFF032C
`define GPT_ADDR_CAPTURE   32'hFFFF0330
`define GPT_ADDR_STATUS    32'hFFFF0334
`define GPT_ADDR_MASK      32'hFFFF0338

// reset values
`define GPT_LOAD_RST       32'h00000000
`define GPT_VALUE_RST      32'hFFFFFFFF
`define GPT_CONFIG_RST     18'h00000
`define GPT_CAPTURE_RST    32'h00000000
`define GPT_MASK_RST       2'h1

// config field positions
`define GPT_CFG_CAPEN      17
`define GPT_CFG_EVSEL_MSB  16
`define GPT_CFG_EVSEL_LSB  12
`define GPT_CFG_CLK_MSB    11
`define GPT_CFG_CLK_LSB    9
`define GPT_CFG_UP         8
`define GPT_CFG_EN         7
`define GPT_CFG_PERIODIC   6
`define GPT_CFG_FMT_MSB    5
`define GPT_CFG_FMT_LSB    4
`define GPT_CFG_PRE_MSB    3
`define GPT_CFG_PRE_LSB    0
`define GPT_CFG_W          18

// status and mask bit positions
`define GPT_ST_TIMEOUT     0
`define GPT_ST_CAPTURE     1

// event select range and offset into the interrupt list
`define GPT_EVSEL_MAX      5'h19
`define GPT_EVSEL_OFFSET   6'h02

// digit group limits for the time formats
`define GPT_HUND_MAX       8'h63
`define GPT_MINSEC_MAX     8'h3B
`define GPT_HOUR23_MAX     8'h17
`define GPT_HOUR255_MAX    8'hFF

`endif

// *** inc/gp_timer_pkg.sv ***
// types shared by the capture timer
// assumes the constants header is included alongside
package gp_timer_pkg;

    // counter format
    typedef enum logic [1:0] {
        FMT_BINARY = 2'h0,
        FMT_RSVD   = 2'h1,
        FMT_HR23   = 2'h2,
        FMT_HR255  = 2'h3
    } fmt_e;

    // count source
    typedef enum logic [2:0] {
        CS_CORE = 3'h0,
        CS_32K  = 3'h1,
        CS_PLL  = 3'h2,
        CS_PIN  = 3'h3
    } clk_sel_e;

endpackage : gp_timer_pkg

// *** verification/gp_capture_timer_test.sv ***
// self-checking bench for the capture timer: registers, counting, irq, capture
// assumes the design header is on the include path and a single 50 ns clock
`timescale 1ns/1ps
`include "gp_timer_params.svh"

module gp_capture_timer_test;
    logic        i_clock = 1'b0;
    logic        i_srst  = 1'b1;
    logic [31:0] i_addr  = 32'h0;
    logic [31:0] i_wdata = 32'h0;
    logic        i_wr    = 1'b0;
    logic        i_rd    = 1'b0;
    logic [2:0]  pins    = 3'h0;
    logic [27:0] i_irq_lines = 28'h0;
    logic [31:0] o_rdata;
    logic        o_irq;
    logic        o_adc_start;
    logic [31:0] rv;
    int          err_count = 0;
    int          n_tests   = 0;
    int          cyc       = 0;

    gp_capture_timer i_gp_capture_timer (.i_clock(i_clock), .i_srst(i_srst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_xtal_32k(pins[0]), .i_undivided_pll_clock(pins[1]),
        .i_external_count_pin(pins[2]), .i_irq_lines(i_irq_lines), .o_irq(o_irq),
        .o_adc_start(o_adc_start));

    always #25 i_clock = ~i_clock;

    // hang guard: longest case is two full /32768 periods
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("tests=%0d mismatches=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // strobe stays up on return so writes can run back to back
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        i_rd <= 1'b0; i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
        @(posedge i_clock);
    endtask : wr

    task automatic idle();
        i_wr <= 1'b0;
        @(posedge i_clock);
        #1;
    endtask : idle

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        i_wr <= 1'b0; i_rd <= 1'b1; i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask : rd

    task automatic waitc(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : waitc

    task automatic t_reset();
        chk({31'h0, o_irq}, 32'h0);
        rd(`GPT_ADDR_LOAD, `GPT_LOAD_RST);
        rd(`GPT_ADDR_VALUE, `GPT_VALUE_RST);
        rd(`GPT_ADDR_CONFIG, 32'h0);
        rd(`GPT_ADDR_CAPTURE, `GPT_CAPTURE_RST);
        rd(`GPT_ADDR_IRQ_CLEAR, 32'h0);
        rd(`GPT_ADDR_MASK, 32'h1);
        wr(`GPT_ADDR_VALUE, 32'h12345678);
        wr(32'hFFFF0340, 32'hFFFFFFFF);
        rd(`GPT_ADDR_VALUE, `GPT_VALUE_RST);
        rd(32'hFFFF0340, 32'h0);
        wr(`GPT_ADDR_LOAD, 32'hA5A5C3C3);
        rd(`GPT_ADDR_LOAD, 32'hA5A5C3C3);
        wr(`GPT_ADDR_CONFIG, 32'hFFFFFFFF);
        rd(`GPT_ADDR_CONFIG, 32'h0003FFFF);
        wr(`GPT_ADDR_CONFIG, 32'h0);
        rd(`GPT_ADDR_STATUS, 32'h0);
        $display("test reset done");
    endtask : t_reset

    // enable for exactly one edge, so exactly one count tick lands
    task automatic step(input logic [31:0] ld, input logic [31:0] cfg, input logic [31:0] exp);
        wr(`GPT_ADDR_LOAD, ld);
        wr(`GPT_ADDR_CONFIG, cfg | 32'h80);
        wr(`GPT_ADDR_CONFIG, cfg);
        idle();
        rd(`GPT_ADDR_VALUE, exp);
    endtask : step

    task automatic t_steps();
        step(32'h5, 32'h0, 32'h4);
        step(32'h63, 32'h100, 32'h64);
        step(32'h63, 32'h110, 32'h64);
        step(32'h00003B63, 32'h120, 32'h00010000);
        step(32'h173B3B63, 32'h120, 32'h0);
        step(32'h173B3B63, 32'h130, 32'h18000000);
        step(32'hFF3B3B63, 32'h130, 32'h0);
        step(32'h01000000, 32'h020, 32'h003B3B63);
        step(32'hFFFFFFFF, 32'h100, 32'h0);
        wr(`GPT_ADDR_LOAD, 32'h9);
        wr(`GPT_ADDR_CONFIG, 32'h100);
        idle();
        waitc(5);
        rd(`GPT_ADDR_VALUE, 32'h9);
        $display("test steps done");
    endtask : t_steps

    // distance between two conversion-start pulses in periodic mode
    task automatic period(input logic [31:0] ld, input logic [31:0] cfg, input int exp);
        int k;
        wr(`GPT_ADDR_LOAD, ld);
        wr(`GPT_ADDR_CONFIG, cfg | 32'hC0);
        idle();
        for (k = 0; k < 40000 && o_adc_start !== 1'b1; k++) waitc(1);
        for (k = 1; k < 40000; k++) begin
            waitc(1);
            if (o_adc_start === 1'b1) break;
        end
        chk(k, exp);
        wr(`GPT_ADDR_CONFIG, 32'h0);
        idle();
    endtask : period

    task automatic t_period();
        period(32'h3, 32'h0, 4);
        period(32'hFFFFFFFD, 32'h100, 3);
        period(32'h1, 32'h2, 8);
        period(32'h0, 32'h4, 16);
        period(32'h0, 32'h8, 256);
        period(32'h0, 32'hF, 32768);
        $display("test period done");
    endtask : t_period

    task automatic t_irq();
        rd(`GPT_ADDR_STATUS, 32'h1);
        chk({31'h0, o_irq}, 32'h0);
        step(32'h0, 32'h0, 32'hFFFFFFFF);
        chk({31'h0, o_irq}, 32'h1);
        wr(`GPT_ADDR_IRQ_CLEAR, 32'h0);
        idle();
        chk({31'h0, o_irq}, 32'h0);
        wr(`GPT_ADDR_MASK, 32'h0);
        step(32'h0, 32'h0, 32'hFFFFFFFF);
        chk({31'h0, o_irq}, 32'h0);
        rd(`GPT_ADDR_STATUS, 32'h1);
        rd(`GPT_ADDR_STATUS, 32'h0);
        wr(`GPT_ADDR_MASK, 32'h1);
        idle();
        $display("test irq done");
    endtask : t_irq

    task automatic t_sources();
        int s;
        for (s = 1; s <= 4; s++) begin
            wr(`GPT_ADDR_LOAD, 32'hA);
            wr(`GPT_ADDR_CONFIG, 32'h180 | (s << 9));
            idle();
            waitc(10);
            rd(`GPT_ADDR_VALUE, 32'hA);
            pins <= (s == 4) ? 3'h7 : 3'h1 << (s - 1);
            waitc(3);
            pins <= 3'h0;
            waitc(8);
            rd(`GPT_ADDR_VALUE, (s == 4) ? 32'hA : 32'hB);
        end
        wr(`GPT_ADDR_CONFIG, 32'h0);
        idle();
        $display("test sources done");
    endtask : t_sources

    task automatic line(input int n);
        i_irq_lines <= 28'h0;
        waitc(2);
        i_irq_lines[n] <= 1'b1;
        waitc(4);
    endtask : line

    task automatic t_capture();
        wr(`GPT_ADDR_LOAD, 32'h1234);
        wr(`GPT_ADDR_CONFIG, 32'h23000);
        idle();
        line(5);
        rd(`GPT_ADDR_CAPTURE, 32'h1234);
        rd(`GPT_ADDR_STATUS, 32'h2);
        wr(`GPT_ADDR_LOAD, 32'h5678);
        idle();
        waitc(4);
        rd(`GPT_ADDR_CAPTURE, 32'h1234);
        line(4);
        rd(`GPT_ADDR_CAPTURE, 32'h1234);
        wr(`GPT_ADDR_CONFIG, 32'h03000);
        idle();
        line(5);
        rd(`GPT_ADDR_CAPTURE, 32'h1234);
        wr(`GPT_ADDR_CONFIG, 32'h39000);
        idle();
        line(27);
        rd(`GPT_ADDR_CAPTURE, 32'h5678);
        i_irq_lines <= 28'h0;
        $display("test capture done");
    endtask : t_capture

    initial begin
        repeat (16) @(posedge i_clock);
        i_srst <= 1'b0;
        waitc(2);
        t_reset();
        t_steps();
        t_period();
        t_irq();
        t_sources();
        t_capture();
        give_verdict();
    end
endmodule : gp_capture_timer_test
